/* File: verilog/ppfc_pkg.sv */
// Purpose: constants, types and register map of the port pin function block
// Assumes: 32-bit APB, one aligned word per register
package ppfc_pkg;
    localparam int PPFC_IO_W = 4;
    localparam int PPFC_AN_W = 6;
    localparam int PPFC_HI_W = 12;
    localparam int PPFC_MC_CYC = 4;
    localparam logic [7:0] PPFC_A_CTRL = 8'h00;
    localparam logic [7:0] PPFC_A_STAT = 8'h04;
    localparam logic [7:0] PPFC_A_ANCFG = 8'h08;
    localparam logic [7:0] PPFC_A_IRQCFG = 8'h0C;
    localparam logic [7:0] PPFC_A_TONE = 8'h10;
    localparam logic [7:0] PPFC_A_OUTL = 8'h14;
    localparam logic [7:0] PPFC_A_INL = 8'h18;
    localparam logic [7:0] PPFC_A_HIDIR = 8'h1C;
    localparam logic [7:0] PPFC_A_HIDAT = 8'h20;
    localparam logic [7:0] PPFC_A_BITOP = 8'h24;
    localparam logic [7:0] PPFC_A_PC = 8'h28;
    // ctrl write bits
    localparam int PPFC_C_CLOCK_STOP_INSTR = 0;
    localparam int PPFC_C_CONV = 1;
    localparam int PPFC_C_CLRLOSS = 2;
    localparam int PPFC_C_CLRIRQ = 3;
    localparam int PPFC_C_CLRSNS = 4;
    // status read bits
    localparam int PPFC_S_LOSS = 0;
    localparam int PPFC_S_IRQ = 1;
    localparam int PPFC_S_BACKUP = 2;
    localparam int PPFC_S_SNSFF = 3;
    localparam int PPFC_S_SNSPIN = 4;
    localparam int PPFC_S_CONVGO = 5;
    localparam int PPFC_S_EXTIRQ = 8;
    localparam logic [11:0] PPFC_PC_RST = 12'h000;
    typedef enum logic [1:0] {
        PPFC_RUN = 2'b00,
        PPFC_BACKUP = 2'b01
    } ppfc_mode_e;
    typedef struct packed {
        logic [PPFC_IO_W-1:0] o;
        logic [PPFC_IO_W-1:0] oe_n;
    } ppfc_drv_s;
endpackage

/* File: verilog/ppfc_port.sv */
// Purpose: pin function, direction and backup control of the port block
// Assumes: pins are asynchronous and pass two flops; APB slave, zero wait
// Notes: output enables are active low (low means driving)
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module ppfc_port import ppfc_pkg::*; #(
    parameter int HI_W = PPFC_HI_W
) (
    input wire logic pclk, // bus clock
    input wire logic presetn, // power-on reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic reset_pin, // system reset pin, active low
    input wire logic power_monitor, // accessory power monitor pin
    input wire logic voltage_sense, // voltage sense pin
    input wire logic [PPFC_AN_W-1:0] analog_in, // analog group pins
    input wire logic [1:0] irq_shared_io_i, // irq-shared pin levels
    output ppfc_drv_s irq_drv, // irq-shared drive (low 2 bits)
    input wire logic tone_pin_i, // tone-capable pin level
    input wire logic tone_wave, // tone generator output
    output ppfc_drv_s tone_drv, // tone group drive
    output logic [1:0] open_drain_output_oe_n, // open-drain pull low when 0
    input wire logic [HI_W-1:0] hi_i, // high plain groups pins
    output logic [HI_W-1:0] hi_o, // high plain groups drive value
    output logic [HI_W-1:0] hi_oe_n, // high plain groups enables
    output logic [2:0] analog_input_select, // converter channel
    output logic conv_start, // conversion start pulse
    output logic [7:0] tone_freq, // tone frequency code
    output logic [1:0] ext_irq, // external irq pulses
    output logic power_irq, // power monitor irq flag
    output logic backup, // backup mode
    output logic sys_reset, // system reset pulse
    output logic [11:0] pc // program counter
);
    // refuse widths that the read path and setup words cannot carry
    if (HI_W < 1 || HI_W > 16) begin : g_bad_hi_w
        $error("HI_W out of range");
    end

    logic [1:0] s_rst, s_pm, s_sns, s_tone;
    logic [PPFC_AN_W-1:0] s_an0, s_an;
    logic [1:0] s_irq0, s_irq, irq_prev;
    logic [HI_W-1:0] s_hi0, s_hi;
    logic pm_prev;
    logic [2:0] rst_cnt;
    logic power_loss_flag, sns_ff;
    ppfc_mode_e mode;
    logic [PPFC_AN_W-1:0] an_sel;
    logic [1:0] irq_dir, ext_irq_enable_flag, irq_out;
    logic tone_fn, tone_dir;
    logic [3:0] tone_latch;
    logic [HI_W-1:0] hi_dir, hi_lat;
    logic [1:0] od_lat;
    logic wr, rd;
    logic pm_fall;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pm_fall = pm_prev && !s_pm[1];

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_rst <= 2'h3;
            s_pm <= 2'h3;
            s_sns <= 2'h0;
            s_tone <= 2'h0;
            s_an0 <= '0;
            s_an <= '0;
            s_irq0 <= 2'h0;
            s_irq <= 2'h0;
            s_hi0 <= '0;
            s_hi <= '0;
        end else begin
            s_rst <= {s_rst[0], reset_pin};
            s_pm <= {s_pm[0], power_monitor};
            s_sns <= {s_sns[0], voltage_sense};
            s_tone <= {s_tone[0], tone_pin_i};
            s_an0 <= analog_in;
            s_an <= s_an0;
            s_irq0 <= irq_shared_io_i;
            s_irq <= s_irq0;
            s_hi0 <= hi_i;
            s_hi <= s_hi0;
        end
    end

    // reset pin qualification, held low a full machine cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt <= 3'h0;
            sys_reset <= 1'b0;
        end else begin
            sys_reset <= 1'b0;
            if (s_rst[1]) begin
                rst_cnt <= 3'h0;
            end else if (rst_cnt != 3'(PPFC_MC_CYC)) begin
                rst_cnt <= rst_cnt + 3'h1;
                if (rst_cnt == 3'(PPFC_MC_CYC - 1)) sys_reset <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= PPFC_PC_RST;
        end else if (sys_reset) begin
            pc <= PPFC_PC_RST;
        end else if (wr && paddr == PPFC_A_PC) begin
            pc <= pwdata[11:0];
        end
    end

    // power monitor flags; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_prev <= 1'b1;
            power_loss_flag <= 1'b0;
            power_irq <= 1'b0;
            sns_ff <= 1'b1;
        end else begin
            pm_prev <= s_pm[1];
            if (pm_fall) begin
                power_loss_flag <= 1'b1;
                power_irq <= 1'b1;
            end else if (wr && paddr == PPFC_A_CTRL) begin
                if (pwdata[PPFC_C_CLRLOSS]) power_loss_flag <= 1'b0;
                if (pwdata[PPFC_C_CLRIRQ]) power_irq <= 1'b0;
            end
            if (sys_reset) begin
                sns_ff <= 1'b1;
            end else if (wr && paddr == PPFC_A_CTRL && pwdata[PPFC_C_CLRSNS]) begin
                sns_ff <= 1'b0;
            end
        end
    end

    // backup mode entry and exit; the backup output is its own flop, not a decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= PPFC_RUN;
            backup <= 1'b0;
        end else begin
            unique case (mode)
                PPFC_RUN: begin
                    if (wr && paddr == PPFC_A_CTRL && pwdata[PPFC_C_CLOCK_STOP_INSTR] && !s_pm[1]) begin
                        mode <= PPFC_BACKUP;
                        backup <= 1'b1;
                    end
                end
                PPFC_BACKUP: begin
                    if (s_pm[1]) begin
                        mode <= PPFC_RUN;
                        backup <= 1'b0;
                    end
                end
                default: begin
                    mode <= PPFC_RUN;
                    backup <= 1'b0;
                end
            endcase
        end
    end

    // setup latches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_sel <= '0;
            analog_input_select <= 3'h0;
            irq_dir <= 2'h0;
            ext_irq_enable_flag <= 2'h0;
            tone_fn <= 1'b0;
            tone_dir <= 1'b0;
            tone_freq <= 8'h00;
            hi_dir <= '0;
        end else if (wr) begin
            unique case (paddr)
                PPFC_A_ANCFG: begin
                    an_sel <= pwdata[PPFC_AN_W-1:0];
                    analog_input_select <= pwdata[10:8];
                end
                PPFC_A_IRQCFG: begin
                    irq_dir <= pwdata[1:0];
                    ext_irq_enable_flag <= pwdata[5:4];
                end
                PPFC_A_TONE: begin
                    tone_fn <= pwdata[0];
                    tone_dir <= pwdata[1];
                    tone_freq <= pwdata[15:8];
                end
                PPFC_A_HIDIR: hi_dir <= pwdata[HI_W-1:0];
                default: ;
            endcase
        end
    end

    // output latches; bit ops skip the high groups
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_latch <= 4'h0;
            irq_out <= 2'h0;
            od_lat <= 2'h3;
            hi_lat <= '0;
        end else if (wr && paddr == PPFC_A_OUTL) begin
            tone_latch <= pwdata[3:0];
            irq_out <= pwdata[5:4];
            od_lat <= pwdata[9:8];
        end else if (wr && paddr == PPFC_A_BITOP) begin
            // bit index 0..7 over tone, irq, open-drain latches only
            unique case (pwdata[3:0])
                4'h0, 4'h1, 4'h2, 4'h3: tone_latch[pwdata[1:0]] <= pwdata[4];
                4'h4, 4'h5: irq_out[pwdata[0]] <= pwdata[4];
                4'h6, 4'h7: od_lat[pwdata[0]] <= pwdata[4];
                default: ;
            endcase
        end else if (wr && paddr == PPFC_A_HIDAT) begin
            hi_lat <= pwdata[HI_W-1:0];
        end
    end

    // pin drive, all released in backup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_drv <= '{o: '0, oe_n: '1};
            tone_drv <= '{o: '0, oe_n: '1};
            open_drain_output_oe_n <= 2'h3;
            hi_o <= '0;
            hi_oe_n <= '1;
        end else if (mode == PPFC_BACKUP) begin
            irq_drv.oe_n <= '1;
            tone_drv.oe_n <= '1;
            open_drain_output_oe_n <= 2'h3;
            hi_oe_n <= '1;
        end else begin
            irq_drv.o <= {2'h0, irq_out};
            irq_drv.oe_n <= {2'h3, ~irq_dir};
            tone_drv.o[3:1] <= tone_latch[3:1];
            tone_drv.o[0] <= tone_fn ? tone_wave : tone_latch[0];
            tone_drv.oe_n[3:1] <= 3'h0;
            tone_drv.oe_n[0] <= !(tone_fn || tone_dir);
            open_drain_output_oe_n <= od_lat;
            hi_o <= hi_lat;
            hi_oe_n <= ~hi_dir;
        end
    end

    // external irq sense and conversion start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev <= 2'h0;
            ext_irq <= 2'h0;
            conv_start <= 1'b0;
        end else begin
            irq_prev <= s_irq;
            ext_irq <= s_irq & ~irq_prev & ext_irq_enable_flag & ~irq_dir;
            conv_start <= wr && paddr == PPFC_A_CTRL && pwdata[PPFC_C_CONV];
        end
    end

    // apb read path, answered in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > PPFC_A_PC;
            if (rd) begin
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    PPFC_A_STAT: begin
                        prdata[PPFC_S_LOSS] <= power_loss_flag;
                        prdata[PPFC_S_IRQ] <= power_irq;
                        prdata[PPFC_S_BACKUP] <= backup;
                        prdata[PPFC_S_SNSFF] <= sns_ff;
                        prdata[PPFC_S_SNSPIN] <= s_sns[1];
                        prdata[PPFC_S_CONVGO] <= conv_start;
                        prdata[PPFC_S_EXTIRQ +: 2] <= ext_irq;
                    end
                    PPFC_A_ANCFG: prdata[10:0] <= {analog_input_select, 2'h0, an_sel};
                    PPFC_A_IRQCFG: prdata[5:0] <= {ext_irq_enable_flag, 2'h0, irq_dir};
                    PPFC_A_TONE: prdata[15:0] <= {tone_freq, 6'h00, tone_dir, tone_fn};
                    PPFC_A_OUTL: prdata[9:0] <= {od_lat, 2'h0, irq_out, tone_latch};
                    PPFC_A_INL: begin
                        prdata[PPFC_AN_W-1:0] <= backup ? '0 : s_an & ~an_sel;
                        prdata[9:8] <= backup ? 2'h0 : s_irq;
                        prdata[12] <= backup ? 1'b0 : s_tone[1];
                    end
                    PPFC_A_HIDIR: prdata[HI_W-1:0] <= hi_dir;
                    PPFC_A_HIDAT: prdata[HI_W-1:0] <= backup ? '0 : s_hi;
                    PPFC_A_PC: prdata[11:0] <= pc;
                    default: ;
                endcase
            end
        end
    end

    a_backup_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == PPFC_RUN && wr && paddr == PPFC_A_CTRL && pwdata[PPFC_C_CLOCK_STOP_INSTR] && s_pm[1])
        |=> mode == PPFC_RUN) else $error("backup entered with monitor high");
    a_backup_exit: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == PPFC_BACKUP && s_pm[1]) |=> mode == PPFC_RUN)
        else $error("backup not left");
    a_loss_set: assert property (@(posedge pclk) disable iff (!presetn)
        pm_fall |=> power_loss_flag && power_irq)
        else $error("loss flags not set");
    a_backup_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        $past(backup) && backup |-> &hi_oe_n && &tone_drv.oe_n && &irq_drv.oe_n)
        else $error("driver active in backup");
    a_od_release: assert property (@(posedge pclk) disable iff (!presetn)
        $past(backup) |-> open_drain_output_oe_n == 2'h3)
        else $error("open drain pulled in backup");
    a_reset_pc: assert property (@(posedge pclk) disable iff (!presetn)
        sys_reset |=> pc == PPFC_PC_RST && sns_ff)
        else $error("pc or sense not reset");
    a_reset_len: assert property (@(posedge pclk) disable iff (!presetn)
        sys_reset |-> !$past(s_rst[1], 1) && !$past(s_rst[1], 4))
        else $error("reset pulse too early");
    a_reset_once: assert property (@(posedge pclk) disable iff (!presetn)
        sys_reset |=> !sys_reset)
        else $error("reset pulse longer than one cycle");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_irq & ~$past(ext_irq_enable_flag)) == 2'h0)
        else $error("irq while disabled");
    a_tone_latch: assert property (@(posedge pclk) disable iff (!presetn)
        $past(tone_fn) && !$past(backup) |-> tone_drv.o[0] == $past(tone_wave))
        else $error("tone pin follows latch");
    a_tone_outputs: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) && !$past(backup) |-> tone_drv.oe_n[3:1] == 3'h0)
        else $error("tone group output not driven");
    a_conv_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start == ($past(wr) && $past(paddr) == PPFC_A_CTRL && $past(pwdata[PPFC_C_CONV])))
        else $error("conversion start without control write");
    a_bitop_high: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == PPFC_A_BITOP |=> $stable(hi_lat))
        else $error("bit op touched high groups");
    a_setup_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && (paddr == PPFC_A_ANCFG || paddr == PPFC_A_IRQCFG)) |=> $stable(an_sel) && $stable(irq_dir))
        else $error("setup latch changed without write");
    a_adc_low: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == PPFC_A_INL |=> (prdata[PPFC_AN_W-1:0] & $past(an_sel)) == '0)
        else $error("converter bit read high");
endmodule

/* File: test/ppfc_board.sv */
// Purpose: board model around the port block
// Assumes: pull-ups on open-drain lines, pull-down on a released tone pin
// Notes: reset pin held low HOLD_CYC edges at power-up, then on request
`timescale 1ns/1ps
module ppfc_board import ppfc_pkg::*; #(
    parameter int HOLD_CYC = 8
) (
    input wire logic pclk, // clock
    input wire logic rst_req, // bench asks for reset low
    input wire logic [1:0] irq_ext, // external irq sources
    input wire ppfc_drv_s irq_drv, // device irq pin drive
    input wire ppfc_drv_s tone_drv, // device tone drive
    input wire logic [1:0] od_oe_n, // open-drain enables
    output logic reset_pin, // reset pin level
    output logic [1:0] irq_pin, // resolved irq pins
    output logic tone_pin, // resolved tone pin
    output logic [1:0] od_pin // open-drain wire levels
);
    int cnt = 0;
    always @(posedge pclk) begin
        if (cnt < HOLD_CYC) begin
            cnt <= cnt + 1;
        end
    end
    assign reset_pin = (cnt >= HOLD_CYC) && !rst_req;
    assign od_pin = od_oe_n;
    assign irq_pin = (irq_drv.o[1:0] & ~irq_drv.oe_n[1:0]) | (irq_ext & irq_drv.oe_n[1:0]);
    assign tone_pin = tone_drv.oe_n[0] ? 1'h0 : tone_drv.o[0];
endmodule

/* File: test/ppfc_port_tb_top.sv */
// Purpose: self-checking bench of the port pin function block
// Assumes: apb master in the bench, board model for pins
// Notes: one task per scenario, judged before it returns
`timescale 1ns/1ps
module ppfc_port_tb_top import ppfc_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic pready, pslverr, errv, reset_pin, tone_pin, rst_req = 0;
    logic power_monitor = 1, voltage_sense = 1, tone_wave = 0;
    logic [5:0] analog_in = 0;
    logic [1:0] irq_pin, irq_ext = 0, od_oe_n, od_pin, ext_irq;
    ppfc_drv_s irq_drv, tone_drv;
    logic [11:0] hi_i = 12'h3C3, hi_o, hi_oe_n, pc;
    logic [2:0] ain_sel;
    logic [7:0] tone_freq;
    logic conv_start, power_irq, backup, sys_reset;
    int mismatches = 0, checked = 0, n_conv = 0, n_irq1 = 0, n_rst = 0, c;

    ppfc_port u_ppfc_port (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin(reset_pin),
        .power_monitor(power_monitor), .voltage_sense(voltage_sense),
        .analog_in(analog_in), .irq_shared_io_i(irq_pin), .irq_drv(irq_drv),
        .tone_pin_i(tone_pin), .tone_wave(tone_wave), .tone_drv(tone_drv),
        .open_drain_output_oe_n(od_oe_n), .hi_i(hi_i), .hi_o(hi_o), .hi_oe_n(hi_oe_n),
        .analog_input_select(ain_sel), .conv_start(conv_start), .tone_freq(tone_freq),
        .ext_irq(ext_irq), .power_irq(power_irq), .backup(backup),
        .sys_reset(sys_reset), .pc(pc));
    ppfc_board u_ppfc_board (.pclk(pclk), .rst_req(rst_req), .irq_ext(irq_ext),
        .irq_drv(irq_drv), .tone_drv(tone_drv), .od_oe_n(od_oe_n),
        .reset_pin(reset_pin), .irq_pin(irq_pin), .tone_pin(tone_pin), .od_pin(od_pin));

    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // count one-cycle pulses so a doubled or missing pulse shows
    always @(posedge pclk) begin
        if (conv_start === 1'h1) n_conv++;
        if (ext_irq[1] === 1'h1) n_irq1++;
        if (sys_reset === 1'h1) n_rst++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic t_reset_state();
        rd(PPFC_A_STAT);
        chk(rdv[3:0], 4'h8);
        rd(PPFC_A_PC);
        chk(rdv[11:0], PPFC_PC_RST);
        chk({irq_drv.oe_n[1:0], hi_oe_n, tone_drv.oe_n[0]}, 15'h7FFF);
        chk(tone_drv.oe_n[3:1], 3'h0);
        chk(od_pin, 2'h3);
        rd(8'h30);
        chk(errv, 1'h1);
        $display("reset state done");
    endtask
    task automatic t_analog();
        analog_in <= 6'h3F;
        c = n_conv;
        wr(PPFC_A_ANCFG, 32'h305);
        rd(PPFC_A_INL);
        chk(rdv[5:0], 6'h3A);
        chk(ain_sel, 3'h3);
        chk(n_conv - c, 0);
        wr(PPFC_A_CTRL, 32'h2);
        tick(3);
        chk(n_conv - c, 1);
        wr(PPFC_A_ANCFG, 32'h300);
        rd(PPFC_A_INL);
        chk(rdv[5:0], 6'h3F);
        $display("analog done");
    endtask
    task automatic t_tone();
        wr(PPFC_A_TONE, 32'hA503);
        wr(PPFC_A_OUTL, 32'hB);
        tick(3);
        chk(tone_freq, 8'hA5);
        chk(tone_drv.o, 4'hA);
        chk(tone_drv.oe_n[0], 1'h0);
        tone_wave <= 1'h1;
        tick(3);
        chk(tone_drv.o[0], 1'h1);
        tone_wave <= 1'h0;
        wr(PPFC_A_TONE, 32'hA502);
        tick(3);
        chk(tone_drv.o[0], 1'h1);
        $display("tone done");
    endtask
    task automatic t_bitops();
        wr(PPFC_A_HIDIR, 32'hFFF);
        wr(PPFC_A_HIDAT, 32'h0);
        for (int i = 8; i < 16; i++) begin
            wr(PPFC_A_BITOP, 32'h10 | i);
        end
        wr(PPFC_A_BITOP, 32'h14);
        wr(PPFC_A_IRQCFG, 32'h1);
        tick(2);
        chk(hi_o, 12'h000);
        chk(hi_oe_n, 12'h000);
        chk({irq_drv.oe_n[1:0], irq_drv.o[0]}, 3'h5);
        wr(PPFC_A_HIDAT, 32'hA5C);
        tick(2);
        chk(hi_o, 12'hA5C);
        rd(PPFC_A_HIDAT);
        chk(rdv[11:0], 12'h3C3);
        $display("bit ops done");
    endtask
    task automatic t_irq();
        c = n_irq1;
        irq_ext <= 2'h2;
        tick(6);
        chk(n_irq1 - c, 0);
        rd(PPFC_A_INL);
        chk(rdv[9], 1'h1);
        irq_ext <= 2'h0;
        wr(PPFC_A_IRQCFG, 32'h21);
        irq_ext <= 2'h2;
        tick(6);
        chk(n_irq1 - c, 1);
        $display("irq done");
    endtask
    task automatic t_backup();
        wr(PPFC_A_CTRL, 32'h1);
        tick(2);
        chk(backup, 1'h0);
        wr(PPFC_A_OUTL, 32'h0);
        tick(2);
        chk(od_pin, 2'h0);
        power_monitor <= 1'h0;
        tick(6);
        chk(power_irq, 1'h1);
        rd(PPFC_A_STAT);
        chk(rdv[1:0], 2'h3);
        wr(PPFC_A_CTRL, 32'h1);
        tick(2);
        chk(backup, 1'h1);
        chk({od_oe_n, hi_oe_n, tone_drv.oe_n, irq_drv.oe_n[1:0]}, 20'hFFFFF);
        voltage_sense <= 1'h0;
        rd(PPFC_A_INL);
        chk(rdv, 32'h0);
        tick(3);
        rd(PPFC_A_STAT);
        chk(rdv[4], 1'h0);
        voltage_sense <= 1'h1;
        power_monitor <= 1'h1;
        tick(5);
        chk(backup, 1'h0);
        $display("backup done");
    endtask
    task automatic t_sysreset();
        wr(PPFC_A_CTRL, 32'h10);
        wr(PPFC_A_PC, 32'h123);
        rd(PPFC_A_STAT);
        chk(rdv[3], 1'h0);
        c = n_rst;
        rst_req <= 1'h1;
        tick(PPFC_MC_CYC - 1);
        rst_req <= 1'h0;
        tick(10);
        chk(n_rst - c, 0);
        chk(pc, 12'h123);
        rst_req <= 1'h1;
        tick(PPFC_MC_CYC);
        rst_req <= 1'h0;
        tick(10);
        chk(n_rst - c, 1);
        chk(pc, PPFC_PC_RST);
        rd(PPFC_A_STAT);
        chk(rdv[3], 1'h1);
        $display("system reset done");
    endtask

    initial begin
        tick(4);
        presetn <= 1'h1;
        tick(20);
        t_reset_state();
        t_analog();
        t_tone();
        t_bitops();
        t_irq();
        t_backup();
        t_sysreset();
        final_report();
    end
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
endmodule
